// File: rtl/nwlo_defs.svh
// Constants for the network watchdog and logic output block
// Contract
// - Programmable watchdog watches network activity, period from comm_timeout_period.
// - Silence longer than the period drives the network-loss flag on.
// - comm_error_action picks trip with comm_timeout_error code, or no trip.
// - comm_error_action also picks active motor stop or free coast; code 10 picks neither.
// - Two combiner inputs, each chosen from the ten output functions on out_func_in.
// - Operator 00 is AND, 01 is OR, 02 is XOR of A and B.
// - Combined output, option code 09, is on exactly when the result is 1.
// - With a card fitted, card network status uses card_watchdog_period.
`ifndef NWLO_DEFS_SVH
`define NWLO_DEFS_SVH
`define NWLO_CLK_HZ          50000000
`define NWLO_TICK_US         100
`define NWLO_TICK_CYCLES     ((`NWLO_CLK_HZ / 1000000) * `NWLO_TICK_US)
`define NWLO_ADDR_CTRL       12'h000
`define NWLO_ADDR_PERIOD     12'h004
`define NWLO_ADDR_CARD       12'h008
`define NWLO_ADDR_LOGIC      12'h00C
`define NWLO_ADDR_STATUS     12'h010
`define NWLO_CTRL_RST        32'h00000000
`define NWLO_PERIOD_RST      16'h0000
`define NWLO_LOGIC_RST       32'h00000000
`define NWLO_OPT_LOGIC       4'h9
`define NWLO_ERR_CODE        8'h3C
`define NWLO_OP_AND          2'h0
`define NWLO_OP_OR           2'h1
`define NWLO_OP_XOR          2'h2
`endif

// File: rtl/nwlo_pkg.sv
// Types for the network watchdog and logic output block
package nwlo_pkg;
    typedef enum logic [1:0] {
        NWLO_ACT_TRIP_DECEL = 2'b00,
        NWLO_ACT_TRIP_COAST = 2'b01,
        NWLO_ACT_NONE       = 2'b10,
        NWLO_ACT_STOP_ONLY  = 2'b11
    } nwlo_action_t;
    typedef struct packed {
        logic       trip;
        logic       stop;
        logic       coast;
        logic [7:0] code;
    } nwlo_resp_t;
    typedef struct packed {
        logic [3:0] sel_a;
        logic [3:0] sel_b;
        logic [1:0] op;
    } nwlo_logic_cfg_t;
endpackage

// File: rtl/nwlo_wdt.sv
// Watchdog counter on a tick enable, restarted by activity
`timescale 1ns/1ps
`default_nettype none
module nwlo_wdt
    import nwlo_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        tick_in,
    input  wire logic        enable_in,
    input  wire logic        activity_in,
    input  wire logic [15:0] period_in,
    output logic             timeout_out
);
    logic [15:0] count_reg;
    logic        timeout_reg;
    wire         expire = enable_in && tick_in && !activity_in && (count_reg >= period_in);
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg   <= 16'h0000;
            timeout_reg <= 1'b0;
        end else if (!enable_in || activity_in) begin
            count_reg   <= 16'h0000;
            timeout_reg <= 1'b0;
        end else if (tick_in && !timeout_reg) begin
            count_reg <= count_reg + 16'h0001;
            if (expire) begin
                timeout_reg <= 1'b1;
            end
        end
    end
    assign timeout_out = timeout_reg;

    a_restart_clear: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        activity_in |=> (count_reg == 16'h0000) && !timeout_out)
        else $error("Activity did not restart watchdog");
    a_timeout_cause: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(timeout_out) |-> $past(expire))
        else $error("Timeout rose without expiry");
endmodule
`default_nettype wire

// File: rtl/nwlo_top.sv
// Network watchdog, timeout response and logic output combiner with APB
`timescale 1ns/1ps
`default_nettype none
`include "nwlo_defs.svh"
module nwlo_top
    import nwlo_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        net_activity_in,
    input  wire logic        card_present_in,
    input  wire logic        card_activity_in,
    input  wire logic [9:0]  out_func_in,
    output logic             net_loss_out,
    output logic             card_loss_out,
    output logic             trip_out,
    output logic             motor_stop_out,
    output logic             motor_coast_out,
    output logic [7:0]       error_code_out,
    output logic             logic_out
);
    logic [2:0]      ctrl_reg;
    logic [15:0]     period_reg;
    logic [15:0]     card_reg;
    nwlo_logic_cfg_t lcfg_reg;
    nwlo_resp_t      resp_reg;
    nwlo_resp_t      resp_next;
    logic            logic_reg;
    logic [12:0]     tick_cnt_reg;
    logic            tick_reg;
    logic [31:0]     prdata_reg;
    logic            net_to;
    logic            card_to;

    wire          wr_en   = psel && penable && pwrite;
    wire          rd_setup = psel && !penable && !pwrite;
    wire          hit_ctl = (paddr == `NWLO_ADDR_CTRL);
    wire          hit_per = (paddr == `NWLO_ADDR_PERIOD);
    wire          hit_crd = (paddr == `NWLO_ADDR_CARD);
    wire          hit_log = (paddr == `NWLO_ADDR_LOGIC);
    wire          hit_sta = (paddr == `NWLO_ADDR_STATUS);
    wire          mapped  = hit_ctl | hit_per | hit_crd | hit_log | hit_sta;
    wire          wd_en   = ctrl_reg[0];
    wire          clr_trip = wr_en && hit_ctl && pwdata[3];
    nwlo_action_t action;
    assign action = nwlo_action_t'(ctrl_reg[2:1]);

    // Tick of 100 us gives a 6.5 s range on a 16-bit period
    wire tick_wrap = (tick_cnt_reg == 13'(`NWLO_TICK_CYCLES - 1));
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt_reg <= 13'h0000;
            tick_reg     <= 1'b0;
        end else begin
            tick_reg     <= tick_wrap;
            tick_cnt_reg <= tick_wrap ? 13'h0000 : tick_cnt_reg + 13'h0001;
        end
    end

    nwlo_wdt u_net_wdt (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .tick_in     (tick_reg),
        .enable_in   (wd_en),
        .activity_in (net_activity_in),
        .period_in   (period_reg),
        .timeout_out (net_to)
    );

    nwlo_wdt u_card_wdt (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .tick_in     (tick_reg),
        .enable_in   (card_present_in),
        .activity_in (card_activity_in),
        .period_in   (card_reg),
        .timeout_out (card_to)
    );

    // Trip latches until cleared; a new timeout wins over the clear
    wire do_trip  = net_to && (action == NWLO_ACT_TRIP_DECEL || action == NWLO_ACT_TRIP_COAST);
    wire do_coast = net_to && (action == NWLO_ACT_TRIP_COAST);
    wire do_stop  = net_to && (action == NWLO_ACT_TRIP_DECEL || action == NWLO_ACT_STOP_ONLY);
    always_comb begin
        resp_next = resp_reg;
        if (clr_trip) begin
            resp_next = '0;
        end
        if (do_trip) begin
            resp_next.trip = 1'b1;
            resp_next.code = `NWLO_ERR_CODE;
        end
        if (do_stop) begin
            resp_next.stop = 1'b1;
        end
        if (do_coast) begin
            resp_next.coast = 1'b1;
        end
    end

    // Logic combiner
    wire in_a = out_func_in[lcfg_reg.sel_a];
    wire in_b = out_func_in[lcfg_reg.sel_b];
    wire op_and = in_a & in_b;
    wire op_or  = in_a | in_b;
    wire op_xor = in_a ^ in_b;
    wire comb_res = (lcfg_reg.op == `NWLO_OP_AND) ? op_and :
                    (lcfg_reg.op == `NWLO_OP_OR)  ? op_or  :
                    (lcfg_reg.op == `NWLO_OP_XOR) ? op_xor : 1'b0;

    wire [31:0] rd_mux =
        hit_ctl ? {29'h0, ctrl_reg} :
        hit_per ? {16'h0, period_reg} :
        hit_crd ? {16'h0, card_reg} :
        hit_log ? {22'h0, lcfg_reg} :
        hit_sta ? {16'h0, resp_reg.code, 2'h0, logic_reg, card_to, resp_reg.coast,
                   resp_reg.stop, resp_reg.trip, net_to} : 32'h00000000;

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_reg   <= 3'h0;
            period_reg <= `NWLO_PERIOD_RST;
            card_reg   <= `NWLO_PERIOD_RST;
            lcfg_reg   <= '0;
            resp_reg   <= '0;
            logic_reg  <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            resp_reg  <= resp_next;
            logic_reg <= comb_res;
            if (wr_en && hit_ctl) ctrl_reg <= pwdata[2:0];
            if (wr_en && hit_per) period_reg <= pwdata[15:0];
            if (wr_en && hit_crd) card_reg <= pwdata[15:0];
            if (wr_en && hit_log) lcfg_reg <= pwdata[9:0];
            if (rd_setup) prdata_reg <= rd_mux;
        end
    end

    // Captured in setup so read data stands from a flop through the access cycle
    assign prdata          = prdata_reg;
    assign pready          = 1'b1;
    assign pslverr         = psel && penable && !mapped;
    assign net_loss_out    = net_to;
    assign card_loss_out   = card_present_in && card_to;
    assign trip_out        = resp_reg.trip;
    assign motor_stop_out  = resp_reg.stop;
    assign motor_coast_out = resp_reg.coast;
    assign error_code_out  = resp_reg.code;
    assign logic_out       = logic_reg;

    a_trip_follows: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        do_trip |=> trip_out && error_code_out == `NWLO_ERR_CODE)
        else $error("Trip not raised on timeout");
    a_no_trip_mode: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(trip_out) |-> $past(net_to) && ($past(action) == NWLO_ACT_TRIP_DECEL ||
                                              $past(action) == NWLO_ACT_TRIP_COAST))
        else $error("Trip without cause");
    a_coast_stop_excl: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        do_coast |-> !do_stop ##1 motor_coast_out)
        else $error("Coast and stop both chosen");
    a_logic_and: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        lcfg_reg.op == `NWLO_OP_AND |=> logic_out == $past(in_a & in_b))
        else $error("AND result wrong");
    a_logic_xor: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        lcfg_reg.op == `NWLO_OP_XOR |=> logic_out == $past(in_a ^ in_b))
        else $error("XOR result wrong");
    a_logic_or: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        lcfg_reg.op == `NWLO_OP_OR |=> logic_out == $past(in_a | in_b))
        else $error("OR result wrong");
    a_loss_window: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        net_activity_in |=> !net_loss_out)
        else $error("Loss flag after activity");
    a_card_gate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !card_present_in |=> !card_to && !card_loss_out)
        else $error("Card loss without card");
    c_net_loss:  cover property (@(posedge sys_clk_in) $rose(net_loss_out));
    c_trip:      cover property (@(posedge sys_clk_in) $rose(trip_out));
    c_card_loss: cover property (@(posedge sys_clk_in) $rose(card_loss_out));
    c_logic:     cover property (@(posedge sys_clk_in) $rose(logic_out));
endmodule
`default_nettype wire

// File: testbench/nwlo_net_master.sv
// Network master model sending periodic activity pulses
`timescale 1ns/1ps
`default_nettype none
module nwlo_net_master #(
    parameter int GAP = 1000
) (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    input  wire logic run_in,
    output logic      activity_out
);
    int cnt_reg;
    // Silent while stopped, so a pause is a real pause
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg      <= 0;
            activity_out <= 1'b0;
        end else if (!run_in) begin
            cnt_reg      <= 0;
            activity_out <= 1'b0;
        end else begin
            cnt_reg      <= (cnt_reg == GAP - 1) ? 0 : cnt_reg + 1;
            activity_out <= (cnt_reg == 0);
        end
    end
endmodule
`default_nettype wire

// File: testbench/net_watchdog_logic_output_bench.sv
// Self-checking bench for the watchdog and logic combiner
`timescale 1ns/1ps
`default_nettype none
`include "nwlo_defs.svh"
module net_watchdog_logic_output_bench;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, net_activity_in, net_loss_out, card_loss_out;
    logic        trip_out, motor_stop_out, motor_coast_out, logic_out;
    logic        card_present_in = 1'b0;
    logic        card_act = 1'b0;
    logic [9:0]  out_func_in = 10'h000;
    logic [7:0]  error_code_out;
    logic        run = 1'b0;
    logic [31:0] rd;
    logic        er;
    int          n_fail = 0;
    int          n_tests = 0;
    int          cyc = 0;

    nwlo_top dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .net_activity_in(net_activity_in), .card_present_in(card_present_in),
        .card_activity_in(card_act), .out_func_in(out_func_in),
        .net_loss_out(net_loss_out), .card_loss_out(card_loss_out),
        .trip_out(trip_out), .motor_stop_out(motor_stop_out),
        .motor_coast_out(motor_coast_out), .error_code_out(error_code_out),
        .logic_out(logic_out));
    nwlo_net_master master (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .run_in(run),
        .activity_out(net_activity_in));

    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end

    // Tests need about 65k cycles; the margin covers slow tick phases
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask

    // Bound covers three tick intervals plus slack
    task automatic wait_hi(input logic card);
        for (int i = 0; i < 20000; i++) begin
            if ((card ? card_loss_out : net_loss_out) === 1'b1) break;
            @(posedge sys_clk_in);
        end
        repeat (2) @(posedge sys_clk_in);
    endtask

    // Long period first, else a tick during the clear retrips at once
    task automatic clr();
        apb(1'b1, `NWLO_ADDR_PERIOD, 32'h0100);
        run <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        run <= 1'b0;
        apb(1'b1, `NWLO_ADDR_CTRL, 32'h8);
        repeat (2) @(posedge sys_clk_in);
        chk(32'({net_loss_out, trip_out, motor_stop_out, motor_coast_out}), 32'h0, "clear");
    endtask

    task automatic t_regs();
        rchk(`NWLO_ADDR_CTRL, 32'h0, "ctrl rst");
        rchk(`NWLO_ADDR_PERIOD, 32'h0, "period rst");
        rchk(`NWLO_ADDR_CARD, 32'h0, "card rst");
        rchk(`NWLO_ADDR_LOGIC, 32'h0, "logic rst");
        apb(1'b1, `NWLO_ADDR_PERIOD, 32'hABC12345);
        rchk(`NWLO_ADDR_PERIOD, 32'h00002345, "period field");
        rchk(12'h014, 32'h0, "unmapped data");
        chk(32'(er), 32'h1, "unmapped err");
        $display("regs test done");
    endtask

    task automatic t_logic();
        logic [1:0] op;
        logic [3:0] sa, sb;
        logic [9:0] f;
        logic       a, b, e;
        for (int k = 0; k < 16; k++) begin
            op = 2'(k >> 2);
            a = k[1];
            b = k[0];
            sa = {2'h0, op};
            sb = 4'h9 - sa;
            e = (op == `NWLO_OP_AND) ? (a & b) : (op == `NWLO_OP_OR) ? (a | b) :
                (op == `NWLO_OP_XOR) ? (a ^ b) : 1'b0;
            f = {10{~a}};
            f[sb] = b;
            f[sa] = a;
            apb(1'b1, `NWLO_ADDR_LOGIC, {22'h0, sa, sb, op});
            out_func_in <= f;
            repeat (3) @(posedge sys_clk_in);
            chk(32'(logic_out), 32'(e), "logic out");
        end
        $display("logic test done");
    endtask

    task automatic t_keep();
        apb(1'b1, `NWLO_ADDR_PERIOD, 32'h2);
        apb(1'b1, `NWLO_ADDR_CTRL, 32'h1);
        run <= 1'b1;
        repeat (20000) begin
            @(posedge sys_clk_in);
            if (net_loss_out !== 1'b0) break;
        end
        chk(32'(net_loss_out), 32'h0, "kept alive");
        run <= 1'b0;
        wait_hi(1'b0);
        chk(32'(net_loss_out), 32'h1, "loss after pause");
        clr();
        $display("keep-alive test done");
    endtask

    task automatic t_act(input logic [1:0] act);
        logic tr, st, co;
        tr = (act < 2'h2);
        st = (act == 2'h0) || (act == 2'h3);
        co = (act == 2'h1);
        apb(1'b1, `NWLO_ADDR_PERIOD, 32'h0);
        apb(1'b1, `NWLO_ADDR_CTRL, {29'h0, act, 1'b1});
        wait_hi(1'b0);
        chk(32'(net_loss_out), 32'h1, "loss flag");
        chk(32'(trip_out), 32'(tr), "trip");
        chk(32'(error_code_out), 32'(tr ? `NWLO_ERR_CODE : 8'h00), "code");
        chk(32'({motor_stop_out, motor_coast_out}), 32'({st, co}), "stop coast");
        apb(1'b0, `NWLO_ADDR_STATUS, 32'h0);
        chk(rd & 32'h0000FF0F, 32'({tr ? `NWLO_ERR_CODE : 8'h00, 4'h0, co, st, tr, 1'b1}),
            "status");
        clr();
        $display("action %0d test done", act);
    endtask

    task automatic t_card();
        chk(32'(card_loss_out), 32'h0, "no card");
        apb(1'b1, `NWLO_ADDR_CARD, 32'h0);
        card_present_in <= 1'b1;
        wait_hi(1'b1);
        chk(32'(card_loss_out), 32'h1, "card loss");
        // Long period first, so a tick right after the pulse cannot retrip
        apb(1'b1, `NWLO_ADDR_CARD, 32'h0100);
        card_act <= 1'b1;
        @(posedge sys_clk_in);
        card_act <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        chk(32'(card_loss_out), 32'h0, "card activity restart");
        apb(1'b1, `NWLO_ADDR_CARD, 32'h0);
        wait_hi(1'b1);
        chk(32'(card_loss_out), 32'h1, "card loss again");
        card_present_in <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        chk(32'(card_loss_out), 32'h0, "card removed");
        $display("card test done");
    endtask

    initial begin
        repeat (6) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        t_regs();
        t_logic();
        t_keep();
        for (int k = 0; k < 4; k++) begin
            t_act(2'(k));
        end
        t_card();
        end_sim();
    end
endmodule
`default_nettype wire
